// ===== ixr_pkg.sv
// Summary of operation
// - start without home return: alarm, no move
// - station above count minus one: warning
// - start ignored while moving; wait completion
// - table mode: speed from selected table
// - direct mode: given speed, table one ramps
// - hold torque limit after in-position delay
// - in-position asserted at power-on on station
// - shortest mode picks shortest travel direction
// - shortest mode ignores station order parameter
// - station count parameter divides one revolution
// - eight tables of speed and ramp times
// - eight select bits give binary station
// - three speed bits pick table index value minus one
// - one station occupied: always table one
// - no registers: speed from point table
// - completion shows station, done, in-position, near
package ixr_pkg;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] IXR_CTRL_OFS = 8'h00;
   localparam logic [7:0] IXR_TARGET_OFS = 8'h04;
   localparam logic [7:0] IXR_SPEED_OFS = 8'h08;
   localparam logic [7:0] IXR_PARAM_OFS = 8'h0C;
   localparam logic [7:0] IXR_TQ_LIMIT_OFS = 8'h10;
   localparam logic [7:0] IXR_TQ_HOLD_OFS = 8'h14;
   localparam logic [7:0] IXR_TQ_DELAY_OFS = 8'h18;
   localparam logic [7:0] IXR_STATUS_OFS = 8'h1C;
   localparam logic [7:0] IXR_TQ_EFF_OFS = 8'h20;
   localparam logic [7:0] IXR_TABLE_OFS = 8'h40;
   // ----------------------------------------
   // control field positions
   // ----------------------------------------
   localparam int IXR_C_SERVO = 0;
   localparam int IXR_C_START = 1;
   localparam int IXR_C_DIR = 2;
   localparam int IXR_C_MODE_LO = 3;
   localparam int IXR_C_MODE_HI = 4;
   localparam int IXR_C_SRC = 5;
   localparam int IXR_C_POS_REQ = 6;
   localparam int IXR_C_SPD_REQ = 7;
   localparam int IXR_C_STATION = 8;
   localparam int IXR_C_TABLE = 16;
   localparam int IXR_C_TWO_ST = 19;
   // ----------------------------------------
   // parameter and status field positions
   // ----------------------------------------
   localparam int IXR_P_COUNT = 0;
   localparam int IXR_P_OPSEL = 8;
   localparam int IXR_P_ORDER = 12;
   localparam int IXR_P_DIRECT = 13;
   localparam int IXR_S_DONE = 0;
   localparam int IXR_S_INPOS = 1;
   localparam int IXR_S_NEAR = 2;
   localparam int IXR_S_HOME_ALM = 3;
   localparam int IXR_S_ST_WARN = 4;
   localparam int IXR_S_POS_ACK = 5;
   localparam int IXR_S_SPD_ACK = 6;
   localparam int IXR_S_MOVING = 7;
   localparam int IXR_S_UP = 8;
   localparam int IXR_S_STATION = 16;
   // ----------------------------------------
   // reset values and codes
   // ----------------------------------------
   localparam logic [31:0] IXR_PARAM_RST = 32'h0000_0808;
   localparam logic [3:0] IXR_OPSEL_INDEXER = 4'h8;
   localparam logic [15:0] IXR_TQ_RST = 16'h03E8;
   localparam logic [15:0] IXR_DELAY_RST = 16'h0064;
   localparam int IXR_TABLES = 8;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int IXR_CLK_PERIOD_NS = 25;
   localparam int IXR_MS_NS = 1000000;
   localparam logic [31:0] IXR_CYC_PER_MS = 32'(IXR_MS_NS / IXR_CLK_PERIOD_NS);
   localparam int IXR_STEP_CYCLES = 16;
   typedef enum logic [2:0]
   {
      IXR_IDLE = 3'b001,
      IXR_MOVE = 3'b010,
      IXR_ARRIVE = 3'b100
   } ixr_state_t;
endpackage

// ===== ixr_indexer_core.sv
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
module ixr_indexer_core
   import ixr_pkg::*;
#(
   parameter int STEP_CYCLES = IXR_STEP_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic home_done,
   output logic move_done_flag,
   output logic in_position_flag,
   output logic near_target_flag,
   output logic [7:0] station_out,
   output logic home_alarm,
   output logic station_warning,
   output logic [15:0] active_speed,
   output logic [15:0] active_acc_time,
   output logic [15:0] active_dec_time,
   output logic [15:0] torque_limit_fwd,
   output logic [15:0] torque_limit_rev
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [7:0] ixr_dist(input logic [7:0] from_s, input logic [7:0] to_s, input logic [7:0] n);
      logic [8:0] d;
      d = {1'b0, to_s} - {1'b0, from_s};
      if (to_s < from_s)
      begin
         d = d + {1'b0, n};
      end
      return d[7:0];
   endfunction

   // ----------------------------------------
   // registers and state
   // ----------------------------------------
   logic [31:0] ctrl_reg;
   logic [7:0] target_station_reg;
   logic [15:0] speed_or_table_reg;
   logic [31:0] param_reg;
   logic [15:0] fwd_torque_limit_param;
   logic [15:0] rev_torque_limit_param;
   logic [15:0] hold_torque_limit_param;
   logic [15:0] torque_switch_delay_param;
   logic [15:0] tbl_speed_reg [IXR_TABLES];
   logic [15:0] tbl_acc_reg [IXR_TABLES];
   logic [15:0] tbl_dec_reg [IXR_TABLES];
   logic [7:0] pos_latch_reg;
   logic [15:0] spd_latch_reg;
   logic pos_ack_reg;
   logic spd_ack_reg;
   logic start_prev_reg;
   ixr_state_t state_reg;
   logic [7:0] cur_station_reg;
   logic [7:0] goal_reg;
   logic step_up_reg;
   logic [15:0] step_cnt_reg;
   logic [31:0] tq_cnt_reg;
   logic hold_reg;

   logic wr_en;
   logic rd_en;
   logic tbl_hit;
   logic [2:0] tbl_sel;
   logic [1:0] tbl_word;
   logic addr_ok;
   logic [7:0] station_count_param;
   logic [3:0] operation_select_param;
   logic station_order_dir_param;
   logic speed_direct;
   logic move_start_cmd;
   logic rotation_dir_cmd;
   logic op_mode_sel_low;
   logic op_mode_sel_high;
   logic pos_speed_source_sel;
   logic two_stations;
   logic start_rise;
   logic mode_ok;
   logic shortest_mode;
   logic [7:0] sel_target;
   logic [2:0] sel_table;
   logic [7:0] dist_up;
   logic [7:0] dist_down;
   logic launch;
   logic [7:0] next_station;

   assign station_count_param = param_reg[IXR_P_COUNT +: 8];
   assign operation_select_param = param_reg[IXR_P_OPSEL +: 4];
   assign station_order_dir_param = param_reg[IXR_P_ORDER];
   assign speed_direct = param_reg[IXR_P_DIRECT];
   assign move_start_cmd = ctrl_reg[IXR_C_START];
   assign rotation_dir_cmd = ctrl_reg[IXR_C_DIR];
   assign op_mode_sel_low = ctrl_reg[IXR_C_MODE_LO];
   assign op_mode_sel_high = ctrl_reg[IXR_C_MODE_HI];
   assign pos_speed_source_sel = ctrl_reg[IXR_C_SRC];
   assign two_stations = ctrl_reg[IXR_C_TWO_ST];

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   // tables fill 0x40 to 0xBF, so the top table index bit is address bit seven
   assign tbl_hit = (paddr[7:6] == 2'b01) || (paddr[7:6] == 2'b10);
   assign tbl_sel = {paddr[7], paddr[5:4]};
   assign tbl_word = paddr[3:2];
   assign addr_ok = (tbl_hit && tbl_word != 2'b11) || paddr <= IXR_TQ_EFF_OFS;
   assign pslverr = psel & penable & (~addr_ok | (paddr[1:0] != 2'b00));

   always_comb
   begin
      prdata = 32'h0000_0000;
      if (rd_en)
      begin
         if (tbl_hit)
         begin
            unique case (tbl_word)
               2'b00: prdata = {16'h0000, tbl_speed_reg[tbl_sel]};
               2'b01: prdata = {16'h0000, tbl_acc_reg[tbl_sel]};
               2'b10: prdata = {16'h0000, tbl_dec_reg[tbl_sel]};
               2'b11: prdata = 32'h0000_0000;
            endcase
         end
         else
         begin
            case (paddr)
               IXR_CTRL_OFS: prdata = ctrl_reg;
               IXR_TARGET_OFS: prdata = {24'h000000, target_station_reg};
               IXR_SPEED_OFS: prdata = {16'h0000, speed_or_table_reg};
               IXR_PARAM_OFS: prdata = param_reg;
               IXR_TQ_LIMIT_OFS: prdata = {rev_torque_limit_param, fwd_torque_limit_param};
               IXR_TQ_HOLD_OFS: prdata = {16'h0000, hold_torque_limit_param};
               IXR_TQ_DELAY_OFS: prdata = {16'h0000, torque_switch_delay_param};
               IXR_STATUS_OFS:
               begin
                  prdata[IXR_S_DONE] = move_done_flag;
                  prdata[IXR_S_INPOS] = in_position_flag;
                  prdata[IXR_S_NEAR] = near_target_flag;
                  prdata[IXR_S_HOME_ALM] = home_alarm;
                  prdata[IXR_S_ST_WARN] = station_warning;
                  prdata[IXR_S_POS_ACK] = pos_ack_reg;
                  prdata[IXR_S_SPD_ACK] = spd_ack_reg;
                  prdata[IXR_S_MOVING] = (state_reg != IXR_IDLE);
                  prdata[IXR_S_UP] = step_up_reg;
                  prdata[IXR_S_STATION +: 8] = station_out;
               end
               IXR_TQ_EFF_OFS: prdata = {torque_limit_rev, torque_limit_fwd};
               default: prdata = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= 32'h0000_0000;
         target_station_reg <= 8'h00;
         speed_or_table_reg <= 16'h0000;
         param_reg <= IXR_PARAM_RST;
         fwd_torque_limit_param <= IXR_TQ_RST;
         rev_torque_limit_param <= IXR_TQ_RST;
         hold_torque_limit_param <= IXR_TQ_RST;
         torque_switch_delay_param <= IXR_DELAY_RST;
      end
      else if (wr_en && !pslverr && !tbl_hit)
      begin
         case (paddr)
            IXR_CTRL_OFS: ctrl_reg <= {12'h000, pwdata[19:0]};
            IXR_TARGET_OFS: target_station_reg <= pwdata[7:0];
            IXR_SPEED_OFS: speed_or_table_reg <= pwdata[15:0];
            IXR_PARAM_OFS: param_reg <= {18'h00000, pwdata[13:0]};
            IXR_TQ_LIMIT_OFS:
            begin
               fwd_torque_limit_param <= pwdata[15:0];
               rev_torque_limit_param <= pwdata[31:16];
            end
            IXR_TQ_HOLD_OFS: hold_torque_limit_param <= pwdata[15:0];
            IXR_TQ_DELAY_OFS: torque_switch_delay_param <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // eight tables of speed and ramp times
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < IXR_TABLES; i++)
         begin
            tbl_speed_reg[i] <= 16'h0000;
            tbl_acc_reg[i] <= 16'h0000;
            tbl_dec_reg[i] <= 16'h0000;
         end
      end
      else if (wr_en && tbl_hit && !pslverr)
      begin
         unique case (tbl_word)
            2'b00: tbl_speed_reg[tbl_sel] <= pwdata[15:0];
            2'b01: tbl_acc_reg[tbl_sel] <= pwdata[15:0];
            2'b10: tbl_dec_reg[tbl_sel] <= pwdata[15:0];
            2'b11: ;
         endcase
      end
   end

   // ----------------------------------------
   // execution request handshake
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pos_latch_reg <= 8'h00;
         spd_latch_reg <= 16'h0000;
         pos_ack_reg <= 1'b0;
         spd_ack_reg <= 1'b0;
      end
      else
      begin
         pos_ack_reg <= ctrl_reg[IXR_C_POS_REQ];
         spd_ack_reg <= ctrl_reg[IXR_C_SPD_REQ];
         if (ctrl_reg[IXR_C_POS_REQ] && !pos_ack_reg)
         begin
            pos_latch_reg <= target_station_reg;
         end
         if (ctrl_reg[IXR_C_SPD_REQ] && !spd_ack_reg)
         begin
            spd_latch_reg <= speed_or_table_reg;
         end
      end
   end

   // ----------------------------------------
   // start decode and selections
   // ----------------------------------------
   assign start_rise = move_start_cmd & ~start_prev_reg;
   assign mode_ok = ctrl_reg[IXR_C_SERVO] & op_mode_sel_high & (operation_select_param == IXR_OPSEL_INDEXER);
   assign shortest_mode = op_mode_sel_low & op_mode_sel_high;
   assign sel_target = pos_speed_source_sel ? pos_latch_reg : ctrl_reg[IXR_C_STATION +: 8];
   always_comb
   begin
      if (pos_speed_source_sel)
      begin
         sel_table = speed_direct ? 3'h0 : 3'(spd_latch_reg[2:0] - 3'h1);
      end
      else
      begin
         sel_table = two_stations ? ctrl_reg[IXR_C_TABLE +: 3] : 3'h0;
      end
   end
   assign dist_up = ixr_dist(cur_station_reg, sel_target, station_count_param);
   assign dist_down = ixr_dist(sel_target, cur_station_reg, station_count_param);
   assign launch = start_rise && state_reg == IXR_IDLE && mode_ok && home_done &&
                   sel_target < station_count_param;
   assign next_station = step_up_reg ?
                         ((cur_station_reg + 8'h01 == station_count_param) ? 8'h00 : cur_station_reg + 8'h01) :
                         ((cur_station_reg == 8'h00) ? station_count_param - 8'h01 : cur_station_reg - 8'h01);

   // ----------------------------------------
   // alarm and warning, write one to clear, set wins
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         home_alarm <= 1'b0;
         station_warning <= 1'b0;
         start_prev_reg <= 1'b0;
      end
      else
      begin
         start_prev_reg <= move_start_cmd;
         if (start_rise && state_reg == IXR_IDLE && mode_ok && !home_done)
         begin
            home_alarm <= 1'b1;
         end
         else if (wr_en && paddr == IXR_STATUS_OFS && pwdata[IXR_S_HOME_ALM])
         begin
            home_alarm <= 1'b0;
         end
         if (start_rise && state_reg == IXR_IDLE && mode_ok && home_done && sel_target >= station_count_param)
         begin
            station_warning <= 1'b1;
         end
         else if (wr_en && paddr == IXR_STATUS_OFS && pwdata[IXR_S_ST_WARN])
         begin
            station_warning <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // motion sequencer
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= IXR_IDLE;
         cur_station_reg <= 8'h00;
         goal_reg <= 8'h00;
         step_up_reg <= 1'b1;
         step_cnt_reg <= 16'h0000;
         active_speed <= 16'h0000;
         active_acc_time <= 16'h0000;
         active_dec_time <= 16'h0000;
         move_done_flag <= 1'b0;
         in_position_flag <= 1'b1;
         near_target_flag <= 1'b1;
         station_out <= 8'h00;
      end
      else
      begin
         unique case (state_reg)
            IXR_IDLE:
            begin
               if (launch)
               begin
                  goal_reg <= sel_target;
                  active_speed <= (pos_speed_source_sel && speed_direct) ? spd_latch_reg : tbl_speed_reg[sel_table];
                  active_acc_time <= tbl_acc_reg[sel_table];
                  active_dec_time <= tbl_dec_reg[sel_table];
                  if (shortest_mode)
                  begin
                     step_up_reg <= (dist_up <= dist_down);
                  end
                  else
                  begin
                     step_up_reg <= rotation_dir_cmd ^ station_order_dir_param;
                  end
                  step_cnt_reg <= 16'h0000;
                  move_done_flag <= 1'b0;
                  in_position_flag <= 1'b0;
                  near_target_flag <= 1'b0;
                  state_reg <= (sel_target == cur_station_reg) ? IXR_ARRIVE : IXR_MOVE;
               end
            end
            IXR_MOVE:
            begin
               if (step_cnt_reg == 16'(STEP_CYCLES - 1))
               begin
                  step_cnt_reg <= 16'h0000;
                  cur_station_reg <= next_station;
                  if (next_station == goal_reg)
                  begin
                     state_reg <= IXR_ARRIVE;
                  end
               end
               else
               begin
                  step_cnt_reg <= step_cnt_reg + 16'h0001;
               end
               near_target_flag <= (next_station == goal_reg);
            end
            IXR_ARRIVE:
            begin
               station_out <= cur_station_reg;
               move_done_flag <= 1'b1;
               in_position_flag <= 1'b1;
               near_target_flag <= 1'b1;
               state_reg <= IXR_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // torque limit switching
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tq_cnt_reg <= 32'h0000_0000;
         hold_reg <= 1'b0;
      end
      else if (!in_position_flag || state_reg != IXR_IDLE || launch)
      begin
         tq_cnt_reg <= 32'h0000_0000;
         hold_reg <= 1'b0;
      end
      else if (tq_cnt_reg >= 32'(torque_switch_delay_param) * IXR_CYC_PER_MS)
      begin
         hold_reg <= 1'b1;
      end
      else
      begin
         tq_cnt_reg <= tq_cnt_reg + 32'h0000_0001;
      end
   end
   assign torque_limit_fwd = hold_reg ? hold_torque_limit_param : fwd_torque_limit_param;
   assign torque_limit_rev = hold_reg ? hold_torque_limit_param : rev_torque_limit_param;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   home_alarm_a: assert property (start_rise && state_reg == IXR_IDLE && mode_ok && !home_done
      |=> home_alarm && state_reg == IXR_IDLE) else $error("home alarm missing");
   station_warn_a: assert property (start_rise && state_reg == IXR_IDLE && mode_ok && home_done &&
      sel_target >= station_count_param |=> station_warning && state_reg == IXR_IDLE)
      else $error("station warning missing");
   start_ignore_a: assert property (state_reg == IXR_MOVE && start_rise |=> $stable(goal_reg))
      else $error("start taken while moving");
   direct_speed_a: assert property (launch && pos_speed_source_sel && speed_direct
      |=> active_speed == $past(spd_latch_reg) && active_acc_time == tbl_acc_reg[0])
      else $error("direct speed wrong");
   one_station_a: assert property (launch && !pos_speed_source_sel && !two_stations
      |=> active_speed == tbl_speed_reg[0]) else $error("one station table wrong");
   torque_move_a: assert property (state_reg == IXR_MOVE |-> torque_limit_fwd == fwd_torque_limit_param &&
      torque_limit_rev == rev_torque_limit_param) else $error("torque limit while moving");
   done_outputs_a: assert property (state_reg == IXR_ARRIVE |=> move_done_flag && in_position_flag &&
      near_target_flag && station_out == goal_reg) else $error("completion outputs wrong");
   shortest_dir_a: assert property (launch && shortest_mode && dist_up < dist_down
      |=> step_up_reg) else $error("not shortest direction");
   exec_ack_a: assert property ($rose(ctrl_reg[IXR_C_POS_REQ]) |=> pos_ack_reg &&
      pos_latch_reg == $past(target_station_reg)) else $error("position request not latched");

   move_done_c: cover property (state_reg == IXR_MOVE ##[1:300] state_reg == IXR_ARRIVE);
   alarm_c: cover property ($rose(home_alarm));
   warn_c: cover property ($rose(station_warning));
   hold_c: cover property ($rose(hold_reg));
endmodule // ixr_indexer_core

// ===== ixr_master_model.sv
`timescale 1ns/100ps
module ixr_master_model
   import ixr_pkg::*;
(
   input wire logic pclk,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'hFF;
      pwdata = 32'h0;
   end
   // one transfer; lines are scrambled once released so stale values never look valid
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= ~w;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule // ixr_master_model

// ===== tb_indexer_positioning_command.sv
`timescale 1ns/100ps
module tb_indexer_positioning_command;
   import ixr_pkg::*;
   logic pclk, presetn, home_done, psel, penable, pwrite, pready, pslverr, e;
   logic move_done_flag, in_position_flag, near_target_flag, home_alarm, station_warning;
   logic [7:0] paddr, station_out, st, t;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] active_speed, active_acc_time, active_dec_time, torque_limit_fwd, torque_limit_rev, hold, v;
   logic [15:0] tab [0:7][0:2];
   int err_count, comparisons, cyc;
   ixr_indexer_core #(.STEP_CYCLES(16)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .home_done(home_done), .move_done_flag(move_done_flag),
      .in_position_flag(in_position_flag), .near_target_flag(near_target_flag), .station_out(station_out),
      .home_alarm(home_alarm), .station_warning(station_warning), .active_speed(active_speed),
      .active_acc_time(active_acc_time), .active_dec_time(active_dec_time),
      .torque_limit_fwd(torque_limit_fwd), .torque_limit_rev(torque_limit_rev));
   ixr_master_model m_u (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         end_of_test();
      end
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [63:0] g, input logic [63:0] x);
      comparisons++;
      if (g !== x)
      begin
         err_count++;
         $display("[ERR] %0t mismatch got %h expected %h", $time, g, x);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      m_u.xfer(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a);
      m_u.xfer(1'b0, a, 32'h0, q, e);
   endtask
   // servo on and both mode bits set: shortest rotation mode
   function automatic logic [31:0] ctrl(input logic [7:0] s, input logic [2:0] k, input logic two,
      input logic [3:0] f);
      logic [31:0] c;
      c = 32'h0000_0019;
      c[IXR_C_START] = f[0];
      c[IXR_C_SRC] = f[1];
      c[IXR_C_POS_REQ] = f[2];
      c[IXR_C_SPD_REQ] = f[3];
      c[15:8] = s;
      c[18:16] = k;
      c[IXR_C_TWO_ST] = two;
      return c;
   endfunction
   function automatic int tsel(input int k);
      return (k == 8) ? 0 : k;
   endfunction
   task automatic start(input logic [7:0] s, input logic [2:0] k, input logic two, input logic [3:0] f);
      wr(IXR_CTRL_OFS, ctrl(s, k, two, f & 4'hE));
      wr(IXR_CTRL_OFS, ctrl(s, k, two, f | 4'h1));
      repeat (3) @(posedge pclk);
   endtask
   task automatic wait_done;
      while (move_done_flag !== 1'b1) @(posedge pclk);
   endtask
   task automatic end_of_test;
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      presetn = 1'b0;
      home_done = 1'b0;
      void'($urandom(99));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(IXR_STATUS_OFS);
      chk(q & 32'h7, 32'h6);
      rd(IXR_PARAM_OFS);
      chk(q, IXR_PARAM_RST);
      rd(8'h4C);
      chk({q, e}, 33'h1);
      start(8'h03, 3'h0, 1'b1, 4'h0);
      chk({home_alarm, in_position_flag}, 2'b11);
      wr(IXR_STATUS_OFS, 32'h18);
      home_done <= 1'b1;
      wr(IXR_PARAM_OFS, 32'h0000_1804);
      start(8'h04, 3'h0, 1'b1, 4'h0);
      chk({home_alarm, station_warning, in_position_flag}, 3'b011);
      wr(IXR_STATUS_OFS, 32'h18);
      for (int i = 0; i < 8; i++)
         for (int j = 0; j < 3; j++)
         begin
            tab[i][j] = 16'($urandom);
            wr(IXR_TABLE_OFS + 8'(16 * i + 4 * j), {16'h0, tab[i][j]});
         end
      hold = 16'($urandom);
      wr(IXR_TQ_HOLD_OFS, {16'h0, hold});
      wr(IXR_TQ_DELAY_OFS, 32'h0);
      for (int k = 0; k < 9; k++)
      begin
         t = 8'($urandom % 4);
         start(t, 3'((k == 8) ? 7 : k), k < 8, 4'h0);
         wait_done;
         chk({active_speed, active_acc_time, active_dec_time}, {tab[tsel(k)][0], tab[tsel(k)][1],
            tab[tsel(k)][2]});
         chk({near_target_flag, in_position_flag, station_out}, {2'b11, t});
         repeat (3) @(posedge pclk);
         chk(torque_limit_fwd, hold);
         st = t;
      end
      for (int d = 0; d < 2; d++)
      begin
         t = d ? 8'((st + 1) % 4) : 8'((st + 3) % 4);
         start(t, 3'h1, 1'b1, 4'h0);
         rd(IXR_STATUS_OFS);
         chk(q[8:7], {d[0], 1'b1});
         chk({torque_limit_rev, torque_limit_fwd}, {IXR_TQ_RST, IXR_TQ_RST});
         wr(IXR_CTRL_OFS, ctrl(8'((t + 2) % 4), 3'h1, 1'b1, 4'h0));
         wr(IXR_CTRL_OFS, ctrl(8'((t + 2) % 4), 3'h1, 1'b1, 4'h1));
         wait_done;
         chk(station_out, t);
         st = t;
      end
      v = 16'($urandom);
      t = 8'((st + 2) % 4);
      wr(IXR_PARAM_OFS, 32'h0000_2804);
      wr(IXR_TARGET_OFS, {24'h0, t});
      wr(IXR_SPEED_OFS, {16'h0, v});
      wr(IXR_CTRL_OFS, ctrl(8'h0, 3'h5, 1'b1, 4'hE));
      rd(IXR_STATUS_OFS);
      chk(q[6:5], 2'b11);
      start(8'h0, 3'h5, 1'b1, 4'h2);
      wait_done;
      chk({active_speed, active_acc_time, active_dec_time, station_out}, {v, tab[0][1], tab[0][2], t});
      // direction mode: mode low bit off, direction on, goes up the long way
      t = 8'((t + 3) % 4);
      wr(IXR_CTRL_OFS, ctrl(t, 3'h0, 1'b1, 4'h0) ^ 32'h0000_000C);
      wr(IXR_CTRL_OFS, ctrl(t, 3'h0, 1'b1, 4'h1) ^ 32'h0000_000C);
      rd(IXR_STATUS_OFS);
      chk(q[8:7], 2'b11);
      wait_done;
      chk(station_out, t);
      end_of_test();
   end
endmodule // tb_indexer_positioning_command
